// [design/mds_pkg.sv]
// constants and encodings shared by the multiply, divide and shift unit
package mds_pkg;

    // datapath geometry
    localparam int MDS_DATA_W = 16;
    localparam int MDS_WIDE_W = 32;
    localparam int MDS_NREG   = 8;
    localparam int MDS_SEL_W  = 3;

    // apb geometry and word indices (byte address = index * 4)
    localparam int MDS_ADDR_W = 8;
    localparam int MDS_IDX_W  = 6;
    localparam logic [MDS_IDX_W-1:0] MDS_IDX_CTRL  = 6'h00;
    localparam logic [MDS_IDX_W-1:0] MDS_IDX_OPND  = 6'h01;
    localparam logic [MDS_IDX_W-1:0] MDS_IDX_STAT  = 6'h02;
    localparam logic [MDS_IDX_W-1:0] MDS_IDX_RF_LO = 6'h08;
    localparam logic [MDS_IDX_W-1:0] MDS_IDX_RF_HI = 6'h0f;

    // control word fields
    localparam int MDS_CTRL_OP_LSB  = 0;
    localparam int MDS_CTRL_SEL_LSB = 2;
    localparam int MDS_CTRL_GO_BIT  = 8;

    // status word fields
    localparam int MDS_STAT_BUSY = 0;
    localparam int MDS_STAT_C    = 1;
    localparam int MDS_STAT_V    = 2;
    localparam int MDS_STAT_Z    = 3;
    localparam int MDS_STAT_N    = 4;

    // operation codes
    localparam logic [1:0] MDS_OP_PRODUCT  = 2'h0;
    localparam logic [1:0] MDS_OP_QUOTIENT = 2'h1;
    localparam logic [1:0] MDS_OP_SHIFT    = 2'h2;

    // divider
    localparam int MDS_DIV_STEPS = 32;
    localparam int MDS_CNT_W     = 6;

    // shifter: 80-bit frame, result in bits 47:32
    localparam int MDS_SH_W       = 80;
    localparam int MDS_SH_CNT_W   = 6;
    localparam int MDS_SH_SIGN    = 5;
    localparam int MDS_SH_RES_LSB = 32;
    localparam int MDS_SH_OVF_LSB = 48;
    localparam int MDS_SH_RC_BIT  = 31;
    localparam logic [MDS_SH_CNT_W-1:0] MDS_SH_BIAS = 6'h20;

endpackage : mds_pkg

// [design/mds_divider.sv]
// sequential signed 32 by 16 divider, truncating toward zero
`timescale 1ns/1ps
module mds_divider import mds_pkg::*; (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // request
    input  wire logic                  start,
    input  wire logic [MDS_WIDE_W-1:0] dividend,
    input  wire logic [MDS_DATA_W-1:0] divisor,
    // answer
    output logic                       done,
    output logic [MDS_WIDE_W-1:0]      quotient,
    output logic [MDS_DATA_W-1:0]      remainder
);

    typedef enum logic [0:0] {MDS_DV_IDLE, MDS_DV_RUN} mds_dv_e;

    typedef struct packed {
        mds_dv_e               st;
        logic [MDS_CNT_W-1:0]  cnt;
        logic [MDS_WIDE_W-1:0] q;
        logic [MDS_DATA_W:0]   r;
        logic [MDS_DATA_W-1:0] dv;
        logic                  negq;
        logic                  negr;
        logic                  done;
        logic [MDS_WIDE_W-1:0] quot;
        logic [MDS_DATA_W-1:0] rem;
    } mds_dv_s;

    mds_dv_s s_reg;
    mds_dv_s s_next;

    always_comb begin
        logic [MDS_DATA_W:0] t;
        t = '0;
        s_next = s_reg;
        s_next.done = 1'b0;
        unique case (s_reg.st)
            MDS_DV_IDLE: begin
                if (start) begin
                    // work on magnitudes, fix signs at the end
                    s_next.negq = dividend[MDS_WIDE_W-1] ^ divisor[MDS_DATA_W-1];
                    s_next.negr = dividend[MDS_WIDE_W-1];
                    s_next.q    = dividend[MDS_WIDE_W-1] ? -dividend : dividend;
                    s_next.dv   = divisor[MDS_DATA_W-1] ? -divisor : divisor;
                    s_next.r    = '0;
                    s_next.cnt  = '0;
                    s_next.st   = MDS_DV_RUN;
                end
            end
            MDS_DV_RUN: begin
                t = {s_reg.r[MDS_DATA_W-1:0], s_reg.q[MDS_WIDE_W-1]};
                if (t >= {1'b0, s_reg.dv}) begin
                    s_next.r = t - {1'b0, s_reg.dv};
                    s_next.q = {s_reg.q[MDS_WIDE_W-2:0], 1'b1};
                end else begin
                    s_next.r = t;
                    s_next.q = {s_reg.q[MDS_WIDE_W-2:0], 1'b0};
                end
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt == MDS_CNT_W'(MDS_DIV_STEPS - 1)) begin
                    s_next.quot = s_reg.negq ? -s_next.q : s_next.q;
                    s_next.rem  = s_reg.negr ? -s_next.r[MDS_DATA_W-1:0] : s_next.r[MDS_DATA_W-1:0];
                    s_next.done = 1'b1;
                    s_next.st   = MDS_DV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign done      = s_reg.done;
    assign quotient  = s_reg.quot;
    assign remainder = s_reg.rem;

endmodule : mds_divider

// [design/mds_unit.sv]
// multiply, divide and arithmetic shift unit with an apb register port
`timescale 1ns/1ps
// Summary of operation
// [RL1] product_op forms the signed 32-bit product of register and destination operand.
// [RL2] after product_op, all_clear_flag set when the whole product is zero.
// [RL3] after product_op, msb_set_flag takes product bit 31.
// [RL4] after product_op, spill_bit_flag set when product does not fit sixteen signed bits.
// [RL5] after product_op, result_too_big_flag is always cleared.
// [RL6] product upper half goes into the selected register first.
// [RL7] product lower half then goes into selected register ORed with one.
// [RL8] quotient_op divides the pair selected, selected OR one by the operand.
// [RL9] quotient low half to selected register, remainder to selected OR one.
// [RL10] after quotient_op, msb_set_flag takes quotient bit 15.
// [RL11] after quotient_op, all_clear_flag set when the full quotient is zero.
// [RL12] after quotient_op, spill_bit_flag set exactly when the divisor is zero.
// [RL13] result_too_big_flag set on zero divisor or quotient not fitting sixteen bits.
// [RL14] shift_op shifts the register by signed six-bit count, left positive, right negative.
// [RL15] after shift_op, all_clear_flag set when the stored result is zero.
// [RL16] after shift_op, result_too_big_flag set when the sign changed while shifting.
// [RL17] after shift_op, msb_set_flag takes bit 15 of the stored result.
// [RL18] after shift_op, spill_bit_flag takes last bit out, cleared for zero count.
// [RL19] operation code picks the operation, three-bit field picks register or pair.
// [RL20] completion is signalled; operands stay stable and results wait until then.
module mds_unit import mds_pkg::*; (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [MDS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // sequencer handshake
    output logic                       busy,
    output logic                       op_done,
    // condition flags
    output logic                       msb_set_flag,
    output logic                       all_clear_flag,
    output logic                       result_too_big_flag,
    output logic                       spill_bit_flag
);

    typedef enum logic [2:0] {
        MDS_IDLE,
        MDS_EXEC,
        MDS_DIV_WAIT,
        MDS_WR_HI,
        MDS_WR_LO
    } mds_state_e;

    typedef struct packed {
        mds_state_e                             st;
        logic [MDS_NREG-1:0][MDS_DATA_W-1:0]    rf;
        logic [1:0]                             op;
        logic [MDS_SEL_W-1:0]                   sel;
        logic [MDS_DATA_W-1:0]                  dst;
        logic [MDS_DATA_W-1:0]                  hi;
        logic [MDS_DATA_W-1:0]                  lo;
        logic                                   n;
        logic                                   z;
        logic                                   v;
        logic                                   c;
        logic                                   busy;
        logic                                   done;
        logic                                   div_go;
        logic                                   pready;
        logic                                   pslverr;
        logic [31:0]                            prdata;
    } mds_unit_s;

    mds_unit_s s_reg;
    mds_unit_s s_next;

    logic                  div_done;
    logic [MDS_WIDE_W-1:0] div_quot;
    logic [MDS_DATA_W-1:0] div_rem;

    // operands seen by the datapath
    logic [MDS_SEL_W-1:0]  sel_pair;
    logic [MDS_DATA_W-1:0] opa;
    logic [MDS_DATA_W-1:0] opb;
    logic [MDS_WIDE_W-1:0] prod;
    logic [MDS_SH_CNT_W-1:0] sh_cnt;
    logic [MDS_SH_CNT_W-1:0] sh_amt;
    logic [MDS_SH_W-1:0]   sh_frame;
    logic [MDS_SH_W-1:0]   sh_out;
    logic [MDS_DATA_W-1:0] sh_res;

    assign sel_pair = s_reg.sel | MDS_SEL_W'(1);                     // RL19
    assign opa      = s_reg.rf[s_reg.sel];                          // RL19
    assign opb      = s_reg.rf[sel_pair];
    assign prod     = MDS_WIDE_W'($signed(opa) * $signed(s_reg.dst)); // RL1
    assign sh_cnt   = s_reg.dst[MDS_SH_CNT_W-1:0];
    assign sh_amt   = sh_cnt + MDS_SH_BIAS;                          // RL14
    assign sh_frame = {{(MDS_SH_W-MDS_DATA_W){opa[MDS_DATA_W-1]}}, opa};
    assign sh_out   = sh_frame << sh_amt;                            // RL14
    assign sh_res   = sh_out[MDS_SH_RES_LSB +: MDS_DATA_W];

    mds_divider u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (s_reg.div_go),
        .dividend  ({opa, opb}),                                     // RL8
        .divisor   (s_reg.dst),
        .done      (div_done),
        .quotient  (div_quot),
        .remainder (div_rem)
    );

    always_comb begin
        logic [MDS_IDX_W-1:0] idx;
        logic                 go;
        logic [1:0]           go_op;
        logic                 rf_hit;
        idx    = paddr[MDS_ADDR_W-1:2];
        go     = 1'b0;
        go_op  = pwdata[MDS_CTRL_OP_LSB +: 2];
        rf_hit = (idx >= MDS_IDX_RF_LO) && (idx <= MDS_IDX_RF_HI);
        s_next = s_reg;
        s_next.done    = 1'b0;
        s_next.div_go  = 1'b0;
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;

        // apb access phase: one wait state, then pready
        if (psel && penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.prdata = '0;
            if (pwrite) begin
                if (idx == MDS_IDX_CTRL) begin
                    // a start while busy or with an unused code is dropped
                    if (pwdata[MDS_CTRL_GO_BIT] && !s_reg.busy &&
                        (go_op == MDS_OP_PRODUCT || go_op == MDS_OP_QUOTIENT ||
                         go_op == MDS_OP_SHIFT)) begin
                        go = 1'b1;
                    end
                end else if (idx == MDS_IDX_OPND) begin
                    if (!s_reg.busy) begin
                        s_next.dst = pwdata[MDS_DATA_W-1:0];        // RL20
                    end
                end else if (rf_hit) begin
                    if (!s_reg.busy) begin
                        s_next.rf[idx[MDS_SEL_W-1:0]] = pwdata[MDS_DATA_W-1:0]; // RL20
                    end
                end else if (idx != MDS_IDX_STAT) begin
                    s_next.pslverr = 1'b1;
                end
            end else begin
                if (idx == MDS_IDX_CTRL) begin
                    s_next.prdata[MDS_CTRL_OP_LSB +: 2]          = s_reg.op;
                    s_next.prdata[MDS_CTRL_SEL_LSB +: MDS_SEL_W] = s_reg.sel;
                end else if (idx == MDS_IDX_OPND) begin
                    s_next.prdata[MDS_DATA_W-1:0] = s_reg.dst;
                end else if (idx == MDS_IDX_STAT) begin
                    s_next.prdata[MDS_STAT_BUSY] = s_reg.busy;
                    s_next.prdata[MDS_STAT_C]    = s_reg.c;
                    s_next.prdata[MDS_STAT_V]    = s_reg.v;
                    s_next.prdata[MDS_STAT_Z]    = s_reg.z;
                    s_next.prdata[MDS_STAT_N]    = s_reg.n;
                end else if (rf_hit) begin
                    s_next.prdata[MDS_DATA_W-1:0] = s_reg.rf[idx[MDS_SEL_W-1:0]];
                end else begin
                    s_next.pslverr = 1'b1;
                end
            end
        end

        unique case (s_reg.st)
            MDS_IDLE: begin
                if (go) begin
                    s_next.op   = go_op;                              // RL19
                    s_next.sel  = pwdata[MDS_CTRL_SEL_LSB +: MDS_SEL_W]; // RL19
                    s_next.busy = 1'b1;                              // RL20
                    s_next.st   = MDS_EXEC;
                end
            end
            MDS_EXEC: begin
                case (s_reg.op)
                    MDS_OP_PRODUCT: begin
                        s_next.hi = prod[MDS_WIDE_W-1:MDS_DATA_W];
                        s_next.lo = prod[MDS_DATA_W-1:0];
                        s_next.z  = (prod == '0);                    // RL2
                        s_next.n  = prod[MDS_WIDE_W-1];              // RL3
                        s_next.c  = (prod[MDS_WIDE_W-1:MDS_DATA_W-1] != '0) &&
                                    (prod[MDS_WIDE_W-1:MDS_DATA_W-1] != '1); // RL4
                        s_next.v  = 1'b0;                            // RL5
                        s_next.st = MDS_WR_HI;
                    end
                    MDS_OP_QUOTIENT: begin
                        if (s_reg.dst == '0) begin
                            // nothing stored when dividing by zero
                            s_next.n    = 1'b0;
                            s_next.z    = 1'b0;
                            s_next.c    = 1'b1;                      // RL12
                            s_next.v    = 1'b1;                      // RL13
                            s_next.busy = 1'b0;
                            s_next.done = 1'b1;                      // RL20
                            s_next.st   = MDS_IDLE;
                        end else begin
                            s_next.div_go = 1'b1;                    // RL8
                            s_next.st     = MDS_DIV_WAIT;
                        end
                    end
                    MDS_OP_SHIFT: begin
                        s_next.rf[s_reg.sel] = sh_res;               // RL14
                        s_next.z = (sh_res == '0);                   // RL15
                        s_next.n = sh_res[MDS_DATA_W-1];             // RL17
                        s_next.v = sh_res[MDS_DATA_W-1] ?
                                   (sh_out[MDS_SH_W-1:MDS_SH_OVF_LSB] != '1) :
                                   (sh_out[MDS_SH_W-1:MDS_SH_OVF_LSB] != '0); // RL16
                        if (sh_cnt == '0) begin
                            s_next.c = 1'b0;                         // RL18
                        end else if (sh_cnt[MDS_SH_SIGN]) begin
                            s_next.c = sh_out[MDS_SH_RC_BIT];        // RL18
                        end else begin
                            s_next.c = sh_out[MDS_SH_OVF_LSB];       // RL18
                        end
                        s_next.busy = 1'b0;
                        s_next.done = 1'b1;                          // RL20
                        s_next.st   = MDS_IDLE;
                    end
                    default: begin
                        s_next.busy = 1'b0;
                        s_next.st   = MDS_IDLE;
                    end
                endcase
            end
            MDS_DIV_WAIT: begin
                if (div_done) begin
                    s_next.hi = div_quot[MDS_DATA_W-1:0];            // RL9
                    s_next.lo = div_rem;                             // RL9
                    s_next.n  = div_quot[MDS_DATA_W-1];              // RL10
                    s_next.z  = (div_quot == '0);                    // RL11
                    s_next.c  = 1'b0;                                // RL12
                    s_next.v  = (div_quot[MDS_WIDE_W-1:MDS_DATA_W] !=
                                 {MDS_DATA_W{div_quot[MDS_DATA_W-1]}}); // RL13
                    s_next.st = MDS_WR_HI;
                end
            end
            MDS_WR_HI: begin
                s_next.rf[s_reg.sel] = s_reg.hi;                     // RL6
                s_next.st = MDS_WR_LO;
            end
            MDS_WR_LO: begin
                // an odd register ends up holding the low half, or the remainder after quotient_op
                s_next.rf[sel_pair] = s_reg.lo;                      // RL7
                s_next.busy = 1'b0;
                s_next.done = 1'b1;                                  // RL20
                s_next.st   = MDS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata              = s_reg.prdata;
    assign pready              = s_reg.pready;
    assign pslverr             = s_reg.pslverr;
    assign busy                = s_reg.busy;
    assign op_done             = s_reg.done;
    assign msb_set_flag        = s_reg.n;
    assign all_clear_flag      = s_reg.z;
    assign result_too_big_flag = s_reg.v;
    assign spill_bit_flag      = s_reg.c;

endmodule : mds_unit

// [test/mds_unit_asserts.sv]
// port checks for the multiply, divide and shift unit
`timescale 1ns/1ps
module mds_unit_asserts import mds_pkg::*; (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [MDS_ADDR_W-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // handshake and flags
    input wire logic                  busy,
    input wire logic                  op_done,
    input wire logic                  msb_set_flag,
    input wire logic                  all_clear_flag,
    input wire logic                  result_too_big_flag,
    input wire logic                  spill_bit_flag
);
    logic [1:0] op_q;
    logic [5:0] cnt_q;
    logic       taken, go_w;
    logic [3:0] flags;
    assign taken = psel && penable && !pready;
    assign go_w  = taken && pwrite && !busy && paddr[7:2] == MDS_IDX_CTRL && pwdata[MDS_CTRL_GO_BIT];
    assign flags = {msb_set_flag, all_clear_flag, result_too_big_flag, spill_bit_flag};
    // op as the go write carries it, unused code included, and count as the unit accepts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q  <= 2'h0;
            cnt_q <= 6'h00;
        end else begin
            if (go_w)
                op_q <= pwdata[1:0];
            if (taken && pwrite && !busy && paddr[7:2] == MDS_IDX_OPND)
                cnt_q <= pwdata[5:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_go;
        go_w;
    endsequence
    sequence s_finish;
        op_done && !busy;
    endsequence
    chk_ready_wait: assert property (taken |=> pready) else $error("no answer after access");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    chk_go_starts: assert property (s_go ##0 pwdata[1:0] != 2'h3 |=> busy)
        else $error("operation did not start");
    chk_bad_op: assert property (s_go ##0 pwdata[1:0] == 2'h3 |=> !busy [*2])
        else $error("unknown op started");
    chk_done_ends: assert property (op_done |-> !busy && $past(busy)) else $error("done without busy");
    chk_busy_bound: assert property ($rose(busy) |-> ##[1:60] s_finish) else $error("op never ended");
    chk_busy_fall: assert property ($fell(busy) |-> op_done) else $error("busy fell early");
    chk_flags_hold: assert property (!busy ##1 !busy |-> $stable(flags)) else $error("flags moved idle");
    chk_clear_neg: assert property (all_clear_flag |-> !msb_set_flag)
        else $error("zero and negative together");
    chk_product_flags: assert property (op_done && op_q == MDS_OP_PRODUCT |->
        !result_too_big_flag && !(all_clear_flag && spill_bit_flag)) else $error("product flags wrong");
    chk_div_zero: assert property (op_done && op_q == MDS_OP_QUOTIENT && spill_bit_flag |->
        result_too_big_flag && !all_clear_flag) else $error("divide by zero flags wrong");
    chk_shift_zero: assert property (op_done && op_q == MDS_OP_SHIFT && cnt_q == 6'h00 |->
        !spill_bit_flag && !result_too_big_flag) else $error("zero shift flags wrong");
endmodule : mds_unit_asserts
bind mds_unit mds_unit_asserts u_chk (.*);

// [test/mds_seq_model.sv]
// sequencer model: apb master that runs ops
`timescale 1ns/1ps
module mds_seq_model import mds_pkg::*; (
    // clock
    input wire logic                  pclk,
    // apb master
    output logic                      psel,
    output logic                      penable,
    output logic                      pwrite,
    output logic [MDS_ADDR_W-1:0]     paddr,
    output logic [31:0]               pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // completion
    input wire logic                  op_done
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [MDS_IDX_W-1:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            mds_unit_tb_top.mismatches++;
            mds_unit_tb_top.print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle lines show the inverse
        paddr   <= ~{idx, 2'b00};
        pwdata  <= ~wd;
    endtask : xfer
    task automatic run_op(input logic [1:0] op, input logic [2:0] sel, input logic [15:0] opnd);
        logic [31:0] rd;
        logic        err;
        int          n;
        xfer(1'b1, MDS_IDX_OPND, {16'h0, opnd}, rd, err);
        xfer(1'b1, MDS_IDX_CTRL, {23'h0, 1'b1, 3'h0, sel, op}, rd, err);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (op_done !== 1'b1 && n < 100);
        if (n >= 100) begin
            mds_unit_tb_top.mismatches++;
            mds_unit_tb_top.print_verdict();
        end
    endtask : run_op
endmodule : mds_seq_model

// [test/mds_unit_tb_top.sv]
// self-checking bench for the multiply, divide and shift unit
`timescale 1ns/1ps
module mds_unit_tb_top import mds_pkg::*; ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, op_done, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    logic        msb_set_flag, all_clear_flag, result_too_big_flag, spill_bit_flag;
    int          mismatches = 0;
    int          tests_run = 0;
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    mds_unit uut (.*);
    mds_seq_model seq (.*);
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [MDS_IDX_W-1:0] idx, output logic [31:0] d);
        logic err;
        seq.xfer(1'b0, idx, 32'h0, d, err);
    endtask : rd
    task automatic wr(input logic [MDS_IDX_W-1:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        logic        err;
        seq.xfer(1'b1, idx, d, dummy, err);
    endtask : wr
    // one op on a loaded pair; checks flags, status and both registers
    task automatic run_case(input logic [1:0] op, input logic [2:0] sel, input logic [15:0] x, y, opnd);
        logic signed [31:0] p, q;
        logic [79:0]        f;
        logic [15:0]        ea, eb;
        logic [3:0]         ef;
        logic [31:0]        d;
        logic [2:0]         so;
        so = sel | 3'h1;
        wr(MDS_IDX_RF_LO + {3'h0, so}, {16'h0, y});
        wr(MDS_IDX_RF_LO + {3'h0, sel}, {16'h0, x});
        ea = x;
        eb = (sel == so) ? x : y;
        seq.run_op(op, sel, opnd);
        case (op)
            MDS_OP_PRODUCT: begin
                p = $signed(x) * $signed(opnd);
                ea = (sel == so) ? p[15:0] : p[31:16];
                eb = p[15:0];
                ef = {p[31], p == 0, 1'b0, (p < -32768) || (p > 32767)};
            end
            MDS_OP_QUOTIENT: begin
                if (opnd == 16'h0) begin
                    ef = 4'b0011;
                end else begin
                    q = $signed({x, y}) / $signed(opnd);
                    p = $signed({x, y}) - q * $signed(opnd);
                    ea = q[15:0];
                    eb = p[15:0];
                    ef = {q[15], q == 0, q[31:16] != {16{q[15]}}, 1'b0};
                end
            end
            default: begin
                f = {{64{x[15]}}, x} << (opnd[5:0] + 6'h20);
                ea = f[47:32];
                ef = {f[47], ea == 0, f[79:48] != {32{f[47]}}, opnd[5] ? f[31] : (opnd[5:0] != 0 && f[48])};
            end
        endcase
        if (sel == so) eb = ea;
        chk({28'h0, msb_set_flag, all_clear_flag, result_too_big_flag, spill_bit_flag}, {28'h0, ef});
        rd(MDS_IDX_STAT, d);
        chk(d, {27'h0, ef, 1'b0});
        rd(MDS_IDX_RF_LO + {3'h0, sel}, d);
        chk(d, {16'h0, ea});
        rd(MDS_IDX_RF_LO + {3'h0, so}, d);
        chk(d, {16'h0, eb});
        $display("test op %0d sel %0d done", op, sel);
    endtask : run_case
    initial begin
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({26'h0, busy, op_done, msb_set_flag, all_clear_flag, result_too_big_flag, spill_bit_flag}, 32'h0);
        rd(MDS_IDX_RF_LO, v);
        chk(v, 32'h0);
        $display("test reset done");
        seq.xfer(1'b0, 6'h05, 32'h0, v, e);
        chk({31'h0, e}, 32'h1);
        wr(MDS_IDX_STAT, 32'h0000_001e);
        wr(MDS_IDX_CTRL, 32'h0000_0103);
        rd(MDS_IDX_STAT, v);
        chk(v, 32'h0);
        $display("test map done");
        run_case(MDS_OP_PRODUCT, 3'h2, 16'h7fff, 16'h1111, 16'h7fff);
        run_case(MDS_OP_PRODUCT, 3'h2, 16'h8000, 16'h1111, 16'h0001);
        run_case(MDS_OP_PRODUCT, 3'h2, 16'hffff, 16'h1111, 16'h8000);
        run_case(MDS_OP_PRODUCT, 3'h0, 16'h0000, 16'h2222, 16'h1234);
        run_case(MDS_OP_PRODUCT, 3'h3, 16'h0003, 16'h0003, 16'hfffe);
        run_case(MDS_OP_QUOTIENT, 3'h4, 16'h0001, 16'h0005, 16'h0007);
        run_case(MDS_OP_QUOTIENT, 3'h4, 16'hffff, 16'hfff9, 16'h0002);
        run_case(MDS_OP_QUOTIENT, 3'h4, 16'h0000, 16'h0003, 16'h0007);
        run_case(MDS_OP_QUOTIENT, 3'h6, 16'h0010, 16'h0000, 16'h0001);
        run_case(MDS_OP_QUOTIENT, 3'h4, 16'h1234, 16'h5678, 16'h0000);
        run_case(MDS_OP_SHIFT, 3'h4, 16'h4001, 16'h5a5a, 16'h0000);
        run_case(MDS_OP_SHIFT, 3'h4, 16'h4001, 16'h5a5a, 16'h0001);
        run_case(MDS_OP_SHIFT, 3'h5, 16'h8001, 16'h8001, 16'h0001);
        run_case(MDS_OP_SHIFT, 3'h4, 16'h8000, 16'h5a5a, 16'h003f);
        run_case(MDS_OP_SHIFT, 3'h4, 16'h0003, 16'h5a5a, 16'h0020);
        run_case(MDS_OP_SHIFT, 3'h4, 16'h0001, 16'h5a5a, 16'h001f);
        run_case(MDS_OP_SHIFT, 3'h7, 16'hfff0, 16'hfff0, 16'h003e);
        print_verdict();
    end
endmodule : mds_unit_tb_top
